// ---- logic/sbr_bit_reverse.sv ----
`timescale 1ns/1ns
module sbr_bit_reverse
(
  input  wire logic [sbr_pkg::DATA_W-1:0] src,
  input  wire logic [sbr_pkg::CNT_W-1:0]  count,
  output logic      [sbr_pkg::DATA_W-1:0] aligned
);

  import sbr_pkg::*;

  logic [DATA_W-2:0] mirrored;

  // Bit 7 maps onto itself, so the centre stays put
  always_comb begin
    for (int i = 0; i < DATA_W - 1; i++) begin
      mirrored[i] = src[DATA_W-2-i];
    end
  end

  // Three-bit count caps the shift at seven places
  always_comb begin
    aligned = {1'b0, mirrored >> count};
  end

endmodule

// ---- logic/sbr_pad_alu.sv ----
`timescale 1ns/1ns
module sbr_pad_alu
#(
  parameter int unsigned PAD_COUNT = 16
)
(
  input  wire logic                          clock,
  input  wire logic                          srst,
  input  wire sbr_pkg::sbr_op_t              op,
  input  wire logic [sbr_pkg::ADDR_W-1:0]    reg_addr,
  input  wire logic [sbr_pkg::DATA_W-1:0]    reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic      [sbr_pkg::DATA_W-1:0]    reg_rdata,
  output logic      [sbr_pkg::DATA_W-1:0]    pad_function_result,
  output logic                               flag_zero,
  output logic                               flag_negative,
  output logic                               flag_carry,
  output logic      [sbr_pkg::CNT_W-1:0]     reverse_shift_count
);

  import sbr_pkg::*;

  logic [DATA_W-1:0]    pads [PAD_COUNT];
  logic [PAD_IDX_W-1:0] last_dst;
  logic                 last_valid;

  logic [DATA_W-1:0]    dest_pad_register;
  logic [DATA_W-1:0]    source_pad_register;
  logic [DATA_W-1:0]    reversed_source;
  logic [DATA_W-1:0]    source_operand;
  sbr_alu_res_t         prelim;
  logic [DATA_W-1:0]    next_fn_result;
  logic                 shift_out;
  logic                 next_carry;
  logic                 is_nop;
  logic                 do_writeback;
  logic                 pad_wr_hit;
  logic [PAD_IDX_W-1:0] pad_wr_idx;
  logic [DATA_W-1:0]    processor_status_word;
  logic [DATA_W-1:0]    next_rdata;
  logic                 pad_hit;
  logic                 status_hit;
  logic                 fn_hit;

  // Single-operand operations never look at the source register
  function automatic logic single_operand(input sbr_opcode_t code);
    case (code)
      OP_INC,
      OP_DEC,
      OP_COM,
      OP_CLR:  single_operand = 1'b1;
      default: single_operand = 1'b0;
    endcase
  endfunction

  // 17-bit sum whose top bit is the carry at 2^16
  function automatic logic [DATA_W:0] wide_sum(input logic [DATA_W-1:0] a,
                                                input logic [DATA_W-1:0] b,
                                                input logic              cin);
    wide_sum = {1'b0, a} + {1'b0, b} + {{DATA_W{1'b0}}, cin};
  endfunction

  // Strictly above 2^16: carry out with some low bit still set
  function automatic logic exceeds(input logic [DATA_W:0] s);
    exceeds = s[DATA_W] && (s[DATA_W-1:0] != RST_WORD);
  endfunction

  // Upper half of the map is the pad file
  function automatic logic is_pad_addr(input logic [ADDR_W-1:0] a);
    is_pad_addr = (a[ADDR_W-1] == ADDR_PAD_BASE[ADDR_W-1]);
  endfunction

  function automatic logic is_status_addr(input logic [ADDR_W-1:0] a);
    is_status_addr = (a == ADDR_STATUS);
  endfunction

  function automatic sbr_alu_res_t alu_eval(input sbr_opcode_t       code,
                                            input logic [DATA_W-1:0] d,
                                            input logic [DATA_W-1:0] s);
    logic [DATA_W:0] sum;
    sum      = '0;
    alu_eval = '0;
    case (code)
      OP_ADD: begin
        sum            = wide_sum(d, s, 1'b0);
        alu_eval.value = sum[DATA_W-1:0];
        alu_eval.carry = sum[DATA_W];
      end
      OP_SUB: begin
        sum            = wide_sum(d, ~s, 1'b1);
        alu_eval.value = sum[DATA_W-1:0];
        alu_eval.carry = sum[DATA_W];
      end
      OP_INC: begin
        sum            = wide_sum(d, RST_WORD, 1'b1);
        alu_eval.value = sum[DATA_W-1:0];
        alu_eval.carry = sum[DATA_W];
      end
      OP_DEC: begin
        sum            = wide_sum(d, ALL_ONES, 1'b0);
        alu_eval.value = sum[DATA_W-1:0];
        alu_eval.carry = sum[DATA_W];
      end
      OP_COM: begin
        sum            = wide_sum(d, ALL_ONES, 1'b0);
        alu_eval.value = ~d;
        alu_eval.carry = sum[DATA_W];
      end
      OP_CLR: begin
        sum            = wide_sum(d, ~d, 1'b0);
        alu_eval.value = RST_WORD;
        alu_eval.carry = sum[DATA_W];
      end
      OP_OR: begin
        alu_eval.value = d | s;
        alu_eval.carry = 1'b0;
      end
      OP_AND: begin
        sum            = wide_sum(d & s, d, 1'b0);
        alu_eval.value = d & s;
        alu_eval.carry = exceeds(sum);
      end
      OP_EQUIVALENCE: begin
        sum            = wide_sum(d, ~s, 1'b0);
        alu_eval.value = ~(d ^ s);
        alu_eval.carry = exceeds(sum);
      end
      OP_MOV: begin
        sum            = wide_sum(d & ~s, d | s, 1'b0);
        alu_eval.value = s;
        alu_eval.carry = exceeds(sum);
      end
      default: begin
        alu_eval.value = d;
        alu_eval.carry = 1'b0;
      end
    endcase
  endfunction

  // Operand fetch
  always_comb begin
    dest_pad_register   = pads[op.dst];
    source_pad_register = pads[op.src];
  end

  sbr_bit_reverse u_reverse (
    .src     (source_pad_register),
    .count   (reverse_shift_count),
    .aligned (reversed_source)
  );

  // Reversal only ever touches the source side
  always_comb begin
    if (op.reverse && !single_operand(op.opcode)) begin
      source_operand = reversed_source;
    end else begin
      source_operand = source_pad_register;
    end
  end

  always_comb begin
    prelim = alu_eval(op.opcode, dest_pad_register, source_operand);
  end

  sbr_post_shift u_shift (
    .prelim      (prelim.value),
    .mode        (op.shift),
    .shifted     (next_fn_result),
    .shifted_out (shift_out)
  );

  always_comb begin
    if (op.shift != SH_NONE) begin
      next_carry = shift_out;
    end else begin
      next_carry = prelim.carry;
    end
  end

  // Address decode shared by the write and read paths
  always_comb begin
    pad_hit    = is_pad_addr(reg_addr);
    status_hit = is_status_addr(reg_addr);
    fn_hit     = (reg_addr == ADDR_FN_RES);
  end

  // Only one op port exists, so one operation per cycle holds by construction
  always_comb begin
    is_nop       = (op.opcode == OP_NOP);
    do_writeback = !is_nop && !op.no_load;
    pad_wr_hit   = reg_wr && pad_hit;
    pad_wr_idx   = reg_addr[PAD_IDX_W-1:0];
  end

  // Pad registers; an operation's write-back wins over a software load
  always_ff @(posedge clock) begin
    if (srst) begin
      for (int i = 0; i < PAD_COUNT; i++) begin
        pads[i] <= RST_WORD;
      end
    end else begin
      if (pad_wr_hit) begin
        pads[pad_wr_idx] <= reg_wdata;
      end
      if (do_writeback) begin
        pads[op.dst] <= next_fn_result;
      end
    end
  end

  // Track the destination so a following no-op can show its new contents
  always_ff @(posedge clock) begin
    if (srst) begin
      last_dst   <= '0;
      last_valid <= 1'b0;
    end else if (!is_nop) begin
      last_dst   <= op.dst;
      last_valid <= 1'b1;
    end
  end

  // Function result register
  always_ff @(posedge clock) begin
    if (srst) begin
      pad_function_result <= RST_WORD;
    end else if (!is_nop) begin
      pad_function_result <= next_fn_result;
    end else if (last_valid) begin
      pad_function_result <= pads[last_dst];
    end
  end

  // Flags land on the edge ending the operation, visible next cycle; a no-op holds them
  always_ff @(posedge clock) begin
    if (srst) begin
      flag_zero <= 1'b0;
    end else if (!is_nop) begin
      flag_zero <= (next_fn_result == RST_WORD);
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      flag_negative <= 1'b0;
    end else if (!is_nop) begin
      flag_negative <= next_fn_result[DATA_W-1];
    end
  end

  // Carry follows the shifter whenever a shift modifier is given
  always_ff @(posedge clock) begin
    if (srst) begin
      flag_carry <= 1'b0;
    end else if (!is_nop) begin
      flag_carry <= next_carry;
    end
  end

  // Reverse-shift field is software owned; flags are read only
  always_ff @(posedge clock) begin
    if (srst) begin
      reverse_shift_count <= RST_RSC;
    end else if (reg_wr && status_hit) begin
      reverse_shift_count <= reg_wdata[STAT_RSC_MSB:STAT_RSC_LSB];
    end
  end

  always_comb begin
    processor_status_word                            = RST_WORD;
    processor_status_word[STAT_Z_BIT]                = flag_zero;
    processor_status_word[STAT_N_BIT]                = flag_negative;
    processor_status_word[STAT_C_BIT]                = flag_carry;
    processor_status_word[STAT_RSC_MSB:STAT_RSC_LSB] = reverse_shift_count;
  end

  // Read data stands one cycle after the strobe and is zero otherwise
  always_comb begin
    next_rdata = RST_WORD;
    if (reg_rd) begin
      if (status_hit) begin
        next_rdata = processor_status_word;
      end else if (fn_hit) begin
        next_rdata = pad_function_result;
      end else if (pad_hit) begin
        next_rdata = pads[reg_addr[PAD_IDX_W-1:0]];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      reg_rdata <= RST_WORD;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

endmodule

// ---- logic/sbr_pkg.sv ----
// Function
// - Reverse operator mirrors source bits 0..14, keeps middle bit, clears bit 15.
// - Mirrored 15-bit value shifts right, zeros entering top and bit 15.
// - Alignment shift count comes from status word bits 13 to 15.
// - Alignment shift is at most seven places; smallest direct array is 256.
// - Reversed, aligned value replaces source operand; operation follows the reversal.
// - Single-operand operations use destination only and ignore the reverse field.
// - Two-operand operations read source and destination; only source may reverse.
// - Subtract yields destination minus source.
// - Preliminary result may be shifted; function result reflects all modifiers.
// - Function result is written back unless write-back suppress is given.
// - Carry, negative and zero flags become visible the cycle after the operation.
// - Zero flag on result zero, negative flag on result below zero.
// - No-op after an operation leaves register, function result shows its contents.
// - A no-op leaves carry, negative and zero flags unchanged.
// - Carry holds arithmetic carry, or last bit shifted out when shifted.
// - Carry when sum reaches 2^16 for sub, add, inc, dec, com; OR clears.
// - Equivalence and AND set carry when their sums exceed 2^16.
package sbr_pkg;

  localparam int unsigned DATA_W    = 16;
  localparam int unsigned PAD_IDX_W = 4;
  localparam int unsigned CNT_W     = 3;
  localparam int unsigned ADDR_W    = 5;

  // Status word field positions
  localparam int unsigned STAT_Z_BIT   = 5;
  localparam int unsigned STAT_N_BIT   = 6;
  localparam int unsigned STAT_C_BIT   = 7;
  localparam int unsigned STAT_RSC_LSB = 13;
  localparam int unsigned STAT_RSC_MSB = 15;

  // Register port map
  localparam logic [ADDR_W-1:0] ADDR_STATUS   = 5'h00;
  localparam logic [ADDR_W-1:0] ADDR_FN_RES   = 5'h01;
  localparam logic [ADDR_W-1:0] ADDR_PAD_BASE = 5'h10;

  // Reset values and the all-ones constant
  localparam logic [CNT_W-1:0]  RST_RSC  = 3'h0;
  localparam logic [DATA_W-1:0] RST_WORD = 16'h0000;
  localparam logic [DATA_W-1:0] ALL_ONES = 16'hffff;

  typedef enum logic [3:0] {
    OP_NOP = 4'h0,
    OP_ADD = 4'h1,
    OP_SUB = 4'h2,
    OP_INC = 4'h3,
    OP_DEC = 4'h4,
    OP_COM = 4'h5,
    OP_CLR = 4'h6,
    OP_OR  = 4'h7,
    OP_AND = 4'h8,
    OP_EQUIVALENCE = 4'h9,
    OP_MOV = 4'ha
  } sbr_opcode_t;

  typedef enum logic [1:0] {
    SH_NONE  = 2'h0,
    SH_LEFT  = 2'h1,
    SH_RIGHT = 2'h2,
    SH_ROTR  = 2'h3
  } sbr_shift_t;

  typedef struct packed {
    sbr_opcode_t          opcode;
    logic [PAD_IDX_W-1:0] src;
    logic [PAD_IDX_W-1:0] dst;
    logic                 reverse;
    logic                 no_load;
    sbr_shift_t           shift;
  } sbr_op_t;

  typedef struct packed {
    logic              carry;
    logic [DATA_W-1:0] value;
  } sbr_alu_res_t;

endpackage

// ---- logic/sbr_post_shift.sv ----
`timescale 1ns/1ns
module sbr_post_shift
(
  input  wire logic [sbr_pkg::DATA_W-1:0] prelim,
  input  wire sbr_pkg::sbr_shift_t        mode,
  output logic      [sbr_pkg::DATA_W-1:0] shifted,
  output logic                            shifted_out
);

  import sbr_pkg::*;

  always_comb begin
    shifted     = prelim;
    shifted_out = 1'b0;
    case (mode)
      SH_LEFT: begin
        shifted     = {prelim[DATA_W-2:0], 1'b0};
        shifted_out = prelim[DATA_W-1];
      end
      SH_RIGHT: begin
        shifted     = {1'b0, prelim[DATA_W-1:1]};
        shifted_out = prelim[0];
      end
      SH_ROTR: begin
        shifted     = {prelim[0], prelim[DATA_W-1:1]};
        shifted_out = prelim[0];
      end
      default: begin
        shifted     = prelim;
        shifted_out = 1'b0;
      end
    endcase
  end

endmodule

// ---- verif/sbr_pad_alu_props.sv ----
`timescale 1ns/1ns
module sbr_pad_alu_props #(
  parameter int unsigned PAD_COUNT = 16
)
(
  input wire logic                       clock,
  input wire logic                       srst,
  input wire sbr_pkg::sbr_op_t           op,
  input wire logic [sbr_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [sbr_pkg::DATA_W-1:0] reg_wdata,
  input wire logic                       reg_wr,
  input wire logic                       reg_rd,
  input wire logic [sbr_pkg::DATA_W-1:0] reg_rdata,
  input wire logic [sbr_pkg::DATA_W-1:0] pad_function_result,
  input wire logic                       flag_zero,
  input wire logic                       flag_negative,
  input wire logic                       flag_carry,
  input wire logic [sbr_pkg::CNT_W-1:0]  reverse_shift_count
);
  import sbr_pkg::*;
  logic [CNT_W-1:0]  wr_cnt;
  wire               is_op = op.opcode != OP_NOP;
  wire               plain = is_op && op.shift == SH_NONE;
  wire [DATA_W-1:0]  fn = pad_function_result;
  always_ff @(posedge clock) begin
    wr_cnt <= reg_wdata[15:13];
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  // Op that writes back, then a quiet no-op: fn reloads the same pad
  sequence s_op_then_nop;
    is_op && !op.no_load ##1 !is_op && !reg_wr;
  endsequence
  a_nop_flag_hold: assert property (!is_op |=> $stable({flag_carry, flag_negative, flag_zero}))
    else $error("flags moved on a no-op");
  a_zero_flag_track: assert property (is_op |=> flag_zero == (fn == 16'h0))
    else $error("zero flag disagrees with result");
  a_neg_flag_track: assert property (is_op |=> flag_negative == fn[15])
    else $error("negative flag disagrees with result");
  a_clear_result: assert property (op.opcode == OP_CLR |=> fn == 16'h0 && !flag_carry)
    else $error("clear gave nonzero result or carry");
  a_or_carry_clear: assert property (plain && op.opcode == OP_OR |=> !flag_carry)
    else $error("or left carry set");
  a_inc_carry_wrap: assert property (plain && op.opcode == OP_INC |=> flag_carry == (fn == 16'h0))
    else $error("increment carry wrong");
  a_dec_carry_wrap: assert property (plain && op.opcode == OP_DEC |=> flag_carry == (fn != 16'hffff))
    else $error("decrement carry wrong");
  a_rotr_carry_out: assert property (is_op && op.shift == SH_ROTR |=> flag_carry == fn[15])
    else $error("rotate carry is not the bit moved out");
  a_rsc_field_load: assert property (reg_wr && reg_addr == ADDR_STATUS |=> reverse_shift_count == wr_cnt)
    else $error("shift count not loaded from status write");
  a_nop_fn_reload: assert property (s_op_then_nop |=> $stable(fn))
    else $error("no-op did not show the written pad");
endmodule
bind sbr_pad_alu sbr_pad_alu_props #(.PAD_COUNT(PAD_COUNT)) sbr_pad_alu_props_i (.clock, .srst, .op,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pad_function_result, .flag_zero,
  .flag_negative, .flag_carry, .reverse_shift_count);

// ---- verif/sbr_seq_model.sv ----
`timescale 1ns/1ns
module sbr_seq_model (
  output sbr_pkg::sbr_op_t op
);
  import sbr_pkg::*;
  initial op = '0;
  // One register holds the issued op, so one pad operation per cycle at most
  task automatic issue(input sbr_op_t o);
    op <= o;
  endtask
endmodule

// ---- verif/tb.sv ----
`timescale 1ns/1ns
module tb;
  import sbr_pkg::*;
  localparam sbr_op_t idle_op = '0;
  logic              clock = 1'b0;
  logic              srst = 1'b1;
  sbr_op_t           op;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic              reg_wr = 1'b0;
  logic              reg_rd = 1'b0;
  logic [DATA_W-1:0] reg_rdata, pad_function_result;
  logic              flag_zero, flag_negative, flag_carry;
  logic [CNT_W-1:0]  reverse_shift_count;
  logic [19:0]       expq[$];
  logic              opk = 0, rdk = 0, opk_d = 0, rdk_d = 0, any = 0;
  logic [15:0]       pad[16] = '{default: 16'h0};
  logic [15:0]       mfn = '0;
  logic [2:0]        mflg = '0;
  logic [2:0]        mrsc = '0;
  logic [3:0]        last = '0;
  int                fails = 0, cmp_count = 0;
  always #20 clock = ~clock;
  sbr_seq_model sbr_seq_model_i (.op(op));
  sbr_pad_alu #(.PAD_COUNT(16)) sbr_pad_alu_i (.clock(clock), .srst(srst), .op(op), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pad_function_result(pad_function_result), .flag_zero(flag_zero), .flag_negative(flag_negative),
    .flag_carry(flag_carry), .reverse_shift_count(reverse_shift_count));
  function automatic logic [16:0] gt(input logic [16:0] x, input logic [15:0] v);
    return {x[16] && |x[15:0], v};
  endfunction
  function automatic logic [16:0] alu(input sbr_op_t o);
    logic [15:0] d, s, v;
    logic [16:0] t;
    d = pad[o.dst];
    s = pad[o.src];
    v = '0;
    if (o.reverse) begin
      for (int i = 0; i < 15; i++) v[i] = s[14-i];
      s = v >> mrsc;
    end
    case (o.opcode)
      OP_ADD: t = {1'b0, d} + s;
      OP_SUB: t = {1'b0, d} + {1'b0, ~s} + 17'h1;
      OP_INC: t = {1'b0, d} + 17'h1;
      OP_DEC: t = {1'b0, d} + 17'hffff;
      OP_COM: t = {d != 16'h0, ~d};
      OP_CLR: t = '0;
      OP_OR:  t = {1'b0, d | s};
      OP_AND: t = gt({1'b0, d & s} + d, d & s);
      OP_EQUIVALENCE: t = gt({1'b0, d} + {1'b0, ~s}, ~(d ^ s));
      default: t = gt({1'b0, d & ~s} + {1'b0, d | s}, s);
    endcase
    case (o.shift)
      SH_LEFT:  t = {t[15], t[14:0], 1'b0};
      SH_RIGHT: t = {t[0], 1'b0, t[15:1]};
      SH_ROTR:  t = {t[0], t[0], t[15:1]};
      default: ;
    endcase
    return t;
  endfunction
  // Model runs before the edge, so reads see pre-edge state as the design does
  task automatic cyc(input sbr_op_t o, input logic wr, input logic rd,
                     input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    logic [16:0] r;
    logic        k;
    k = o.opcode != OP_NOP || any;
    if (rd) expq.push_back({4'h8, a == ADDR_STATUS ? {mrsc, 5'h0, mflg, 5'h0} :
                                  a == ADDR_FN_RES ? mfn : a[4] ? pad[a[3:0]] : 16'h0});
    if (o.opcode != OP_NOP) begin
      r = alu(o);
      mfn = r[15:0];
      mflg = {r[16], r[15], r[15:0] == 16'h0};
      last = o.dst;
      any = 1'b1;
    end else if (any) mfn = pad[last];
    if (k) expq.push_back({1'b0, mflg, mfn});
    if (wr && a == ADDR_STATUS) mrsc = d[15:13];
    if (wr && a[4]) pad[a[3:0]] = d;
    if (o.opcode != OP_NOP && !o.no_load) pad[o.dst] = mfn;
    sbr_seq_model_i.issue(o);
    reg_wr <= wr;
    reg_rd <= rd;
    reg_addr <= a;
    reg_wdata <= d;
    opk <= k;
    rdk <= rd;
    @(posedge clock);
  endtask
  task automatic check(input logic [19:0] seen, input string nm);
    logic [19:0] e;
    e = expq.pop_front();
    cmp_count++;
    if (seen !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, seen);
    end
  endtask
  always @(posedge clock) begin
    opk_d <= opk;
    rdk_d <= rdk;
  end
  always @(negedge clock) begin
    if (rdk_d) check({4'h8, reg_rdata}, "reg_rdata");
    if (opk_d) check({1'b0, flag_carry, flag_negative, flag_zero, pad_function_result}, "fn_flags");
  end
  task automatic give_verdict();
    if (fails == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (2000) @(posedge clock);
    fails++;
    give_verdict();
  end
  initial begin
    sbr_op_t o;
    int      k;
    void'($urandom(32'h3a09));
    repeat (10) @(posedge clock);
    srst <= 1'b0;
    for (int i = 0; i < 16; i++) cyc(idle_op, 1'b1, 1'b0, {1'b1, 4'(i)}, 16'($urandom) & 16'hfffe);
    for (int n = 15; n >= 8; n--) begin
      cyc(idle_op, 1'b1, 1'b0, ADDR_STATUS, {3'(15 - n), 13'h0});
      cyc('{OP_ADD, 4'h1, 4'h2, 1'b1, 1'b1, SH_NONE}, 1'b0, 1'b1, ADDR_STATUS, 16'h0);
    end
    cyc(idle_op, 1'b1, 1'b0, ADDR_STATUS, {3'(8 - 3), 13'h0});
    cyc(idle_op, 1'b1, 1'b0, 5'h11, 16'h0180);
    cyc('{OP_ADD, 4'h1, 4'h2, 1'b1, 1'b1, SH_NONE}, 1'b0, 1'b0, '0, '0);
    for (int i = 0; i < 440; i++) begin
      o.opcode = sbr_opcode_t'(i < 40 ? i / 4 + 1 : $urandom_range(10, 0));
      o.shift = sbr_shift_t'(i < 40 ? i % 4 : $urandom_range(3, 0));
      o.src = 4'($urandom);
      o.dst = 4'($urandom);
      o.reverse = 1'($urandom) && !pad[o.src][0];
      o.no_load = 1'($urandom);
      k = $urandom_range(3, 0);
      cyc(o, k == 1, k > 1, 5'($urandom), 16'($urandom));
    end
    repeat (3) cyc(idle_op, 1'b0, 1'b0, '0, '0);
    opk <= 1'b0;
    rdk <= 1'b0;
    repeat (2) @(negedge clock);
    if (expq.size() != 0) begin
      fails++;
      $display("[ERR] expq expected 0 seen %0d", expq.size());
    end
    give_verdict();
  end
endmodule
